// File: rss_defines.svh
// rss_defines.svh: offsets, field positions, reset values and timing for the reset sequencer
`ifndef RSS_DEFINES_SVH
`define RSS_DEFINES_SVH

// ==================================================
// register indices (byte address = 4 * index)
`define RSS_IDX_CAUSE      14'h0813
`define RSS_IDX_PWRCTL2    14'h0814
`define RSS_IDX_CONFIG     14'h0815
`define RSS_IDX_IRQ_STAT   14'h0816
`define RSS_IDX_IRQ_MASK   14'h0817

// ==================================================
// reset values
`define RSS_CAUSE_RST      8'h3D
`define RSS_CONFIG_RST     8'h0F
`define RSS_PWRCTL2_RST    8'h02

// ==================================================
// field positions
`define RSS_IRQ_VIOL       0
`define RSS_IRQ_STKOVR     1
`define RSS_IRQ_STKUNR     2
`define RSS_IRQ_RUN        3
`define RSS_IRQ_WDOG       4
`define RSS_PC2_VIOL       1

// ==================================================
// memory map of the program space, in words
`define RSS_FLASH_WORDS    15'h2000
`define RSS_SAF_BASE       15'h1F80

// ==================================================
// timing
`define RSS_CLK_KHZ        100000
`define RSS_POWERUP_DELAY_TIMER_MS        64
`define RSS_OST_CYCLES     1024
`define RSS_RELEASE_CYCLES 4'd10

`endif

// File: rss_pkg.sv
// rss_pkg.sv: types shared by the reset and start-up sequencer
`default_nettype none

package rss_pkg;

	typedef enum logic [1:0] {
		RSS_HOLD,
		RSS_COUNT,
		RSS_RUN
	} rss_state_e;

	typedef struct packed {
		logic stack_over_flag;
		logic stack_under_flag;
		logic watchdog_window_flag;
		logic watchdog_timeout_flag;
		logic pin_reset_flag;
		logic software_reset_flag;
		logic por_flag;
		logic bor_flag;
	} rss_cause_s;

	typedef struct packed {
		logic [2:0] spare;
		logic       storage_flash_area_en;
		logic       pin_reset_en;
		logic       osc_timer_needed;
		logic [1:0] powerup_delay_select;
	} rss_config_s;

endpackage : rss_pkg

`default_nettype wire

// File: rss_reset_startup_sequencer.sv
// rss_reset_startup_sequencer.sv: reset, start-up sequencing and reset-cause logging
//
// The Avalon-MM slave port is this design's own decision.
`default_nettype none
`include "rss_defines.svh"

module rss_reset_startup_sequencer
	import rss_pkg::*;
#(
	parameter int POWERUP_DELAY_TIMER_CYCLES = `RSS_POWERUP_DELAY_TIMER_MS * `RSS_CLK_KHZ,
	parameter int OST_CYCLES  = `RSS_OST_CYCLES
) (
	// clock and reset
	input  wire logic        clk_sys_in,
	input  wire logic        arst_n_in,
	// supply monitors and reset pin (asynchronous)
	input  wire logic        por_active_in,
	input  wire logic        bor_active_in,
	input  wire logic        external_reset_pin_n_in,
	// core events (same clock)
	input  wire logic        exec_valid_in,
	input  wire logic [14:0] exec_addr_in,
	input  wire logic        stack_over_in,
	input  wire logic        stack_under_in,
	input  wire logic        wdog_window_reset_in,
	input  wire logic        wdog_timeout_reset_in,
	input  wire logic        software_reset_in,
	// core control
	output logic             core_reset_out,
	output logic             irq_block_out,
	// Avalon-MM slave
	input  wire logic [15:0] avs_address_in,
	input  wire logic        avs_read_in,
	input  wire logic        avs_write_in,
	input  wire logic [3:0]  avs_byteenable_in,
	input  wire logic [31:0] avs_writedata_in,
	output logic [31:0]      avs_readdata_out,
	output logic             avs_waitrequest_out,
	// interrupt
	output logic             irq_out
);

	// ==================================================
	// synchronisers
	logic [2:0] sync1_reg;
	logic [2:0] sync2_reg;

	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			sync1_reg <= 3'h7;
			sync2_reg <= 3'h7;
		end else begin
			sync1_reg <= {por_active_in, bor_active_in, ~external_reset_pin_n_in};
			sync2_reg <= sync1_reg;
		end
	end

	logic por_s;
	logic bor_s;
	logic pin_low_s;
	logic supply_rst;
	assign por_s      = sync2_reg[2];
	assign bor_s      = sync2_reg[1];
	assign pin_low_s  = sync2_reg[0];
	assign supply_rst = por_s | bor_s;

	// ==================================================
	// register file state
	rss_cause_s  cause_reg;
	rss_config_s config_reg;
	logic [7:0]  pwrctl2_reg;
	logic [4:0]  irq_stat_reg;
	logic [4:0]  irq_mask_reg;

	logic        acc_ack_reg;
	logic        acc_req;
	logic        wr_go;
	logic [13:0] acc_idx;
	assign acc_req = avs_read_in | avs_write_in;
	assign wr_go   = avs_write_in & acc_ack_reg & avs_byteenable_in[0];
	assign acc_idx = avs_address_in[15:2];

	logic wr_cause;
	logic wr_pc2;
	logic wr_cfg;
	logic wr_stat;
	logic wr_mask;
	assign wr_cause = wr_go && (acc_idx == `RSS_IDX_CAUSE);
	assign wr_pc2   = wr_go && (acc_idx == `RSS_IDX_PWRCTL2);
	assign wr_cfg   = wr_go && (acc_idx == `RSS_IDX_CONFIG);
	assign wr_stat  = wr_go && (acc_idx == `RSS_IDX_IRQ_STAT);
	assign wr_mask  = wr_go && (acc_idx == `RSS_IDX_IRQ_MASK);

	// ==================================================
	// start-up timers: run from supply release, independent of the pin
	logic [22:0] powerup_delay_timer_cnt_reg;
	logic        powerup_delay_timer_done_reg;
	logic [10:0] ost_cnt_reg;
	logic        ost_done_reg;
	logic        powerup_delay_timer_en;
	assign powerup_delay_timer_en = |config_reg.powerup_delay_select;

	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			powerup_delay_timer_cnt_reg  <= 23'h00_0000;
			powerup_delay_timer_done_reg <= 1'b0;
		end else if (supply_rst) begin
			powerup_delay_timer_cnt_reg  <= 23'h00_0000;
			powerup_delay_timer_done_reg <= 1'b0;
		end else if (!powerup_delay_timer_done_reg) begin
			// keeps counting while the pin is low
			powerup_delay_timer_cnt_reg <= powerup_delay_timer_cnt_reg + 23'h00_0001;
			if (powerup_delay_timer_cnt_reg == 23'(POWERUP_DELAY_TIMER_CYCLES - 1)) begin
				powerup_delay_timer_done_reg <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			ost_cnt_reg  <= 11'h000;
			ost_done_reg <= 1'b0;
		end else if (supply_rst) begin
			ost_cnt_reg  <= 11'h000;
			ost_done_reg <= 1'b0;
		end else if (!ost_done_reg) begin
			ost_cnt_reg <= ost_cnt_reg + 11'h001;
			if (ost_cnt_reg == 11'(OST_CYCLES - 1)) begin
				ost_done_reg <= 1'b1;
			end
		end
	end

	// ==================================================
	// execution violation detection
	logic exec_viol;
	// only executed instructions are checked, so prefetches never trip it
	assign exec_viol = exec_valid_in && (core_reset_out == 1'b0) &&
		((exec_addr_in >= `RSS_FLASH_WORDS) ||
		(config_reg.storage_flash_area_en && (exec_addr_in >= `RSS_SAF_BASE)));
	assign irq_block_out = exec_viol;

	logic pin_hold;
	logic internal_rst;
	logic start_ok;
	assign pin_hold     = config_reg.pin_reset_en & pin_low_s;
	assign internal_rst = exec_viol | wdog_window_reset_in | wdog_timeout_reset_in |
		software_reset_in;
	assign start_ok = (powerup_delay_timer_done_reg | ~powerup_delay_timer_en) &
		(ost_done_reg | ~config_reg.osc_timer_needed) & ~pin_hold;

	// ==================================================
	// core reset sequencer
	rss_state_e state_reg;
	logic [3:0] rel_cnt_reg;

	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state_reg   <= RSS_HOLD;
			rel_cnt_reg <= 4'h0;
		end else if (supply_rst) begin
			state_reg   <= RSS_HOLD;
			rel_cnt_reg <= 4'h0;
		end else begin
			case (state_reg)
				RSS_HOLD: begin
					rel_cnt_reg <= 4'h0;
					if (start_ok) begin
						state_reg <= RSS_COUNT;
					end
				end
				RSS_COUNT: begin
					if (!start_ok) begin
						state_reg <= RSS_HOLD;
					end else if (rel_cnt_reg == `RSS_RELEASE_CYCLES - 4'd1) begin
						state_reg <= RSS_RUN;
					end else begin
						rel_cnt_reg <= rel_cnt_reg + 4'h1;
					end
				end
				RSS_RUN: begin
					if (internal_rst || pin_hold) begin
						state_reg <= RSS_HOLD;
					end
				end
				default: begin
					state_reg <= RSS_HOLD;
				end
			endcase
		end
	end

	assign core_reset_out = (state_reg != RSS_RUN);

	logic run_event;
	logic pin_event;
	assign run_event = (state_reg == RSS_COUNT) && start_ok &&
		(rel_cnt_reg == `RSS_RELEASE_CYCLES - 4'd1);
	assign pin_event = (state_reg == RSS_RUN) && pin_hold;

	// ==================================================
	// reset cause register; hardware events win over a software write
	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			cause_reg <= rss_cause_s'(`RSS_CAUSE_RST);
		end else if (supply_rst) begin
			cause_reg.stack_over_flag       <= 1'b0;
			cause_reg.stack_under_flag      <= 1'b0;
			cause_reg.watchdog_window_flag  <= 1'b1;
			cause_reg.watchdog_timeout_flag <= 1'b1;
			cause_reg.pin_reset_flag        <= 1'b1;
			cause_reg.software_reset_flag   <= 1'b1;
			if (por_s) begin
				cause_reg.por_flag <= 1'b0;
				cause_reg.bor_flag <= 1'b1;
			end else begin
				cause_reg.bor_flag <= 1'b0;
			end
		end else begin
			if (wr_cause) begin
				cause_reg <= rss_cause_s'(avs_writedata_in[7:0]);
			end
			if (stack_over_in) begin
				cause_reg.stack_over_flag <= 1'b1;
			end
			if (stack_under_in) begin
				cause_reg.stack_under_flag <= 1'b1;
			end
			if (wdog_window_reset_in) begin
				cause_reg.watchdog_window_flag <= 1'b0;
			end
			if (wdog_timeout_reset_in) begin
				cause_reg.watchdog_timeout_flag <= 1'b0;
			end
			if (pin_event) begin
				cause_reg.pin_reset_flag <= 1'b0;
			end
			if (software_reset_in) begin
				cause_reg.software_reset_flag <= 1'b0;
			end
		end
	end

	// ==================================================
	// second power control register and configuration
	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			pwrctl2_reg <= `RSS_PWRCTL2_RST;
		end else if (supply_rst) begin
			pwrctl2_reg <= `RSS_PWRCTL2_RST;
		end else if (exec_viol) begin
			pwrctl2_reg[`RSS_PC2_VIOL] <= 1'b0;
		end else if (wr_pc2) begin
			pwrctl2_reg[`RSS_PC2_VIOL] <= avs_writedata_in[`RSS_PC2_VIOL];
		end
	end

	// the select field models a nonvolatile word: it survives every reset but arst_n_in
	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			config_reg <= rss_config_s'(`RSS_CONFIG_RST);
		end else if (wr_cfg) begin
			config_reg <= rss_config_s'({3'h0, avs_writedata_in[4:0]});
		end
	end

	// ==================================================
	// interrupts: sticky, write one to clear, set wins
	logic [4:0] irq_ev;
	always_comb begin
		irq_ev                  = 5'h00;
		irq_ev[`RSS_IRQ_VIOL]   = exec_viol;
		irq_ev[`RSS_IRQ_STKOVR] = stack_over_in;
		irq_ev[`RSS_IRQ_STKUNR] = stack_under_in;
		irq_ev[`RSS_IRQ_RUN]    = run_event;
		irq_ev[`RSS_IRQ_WDOG]   = wdog_window_reset_in | wdog_timeout_reset_in;
	end

	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			irq_stat_reg <= 5'h00;
			irq_mask_reg <= 5'h00;
		end else begin
			irq_stat_reg <= (irq_stat_reg & ~(wr_stat ? avs_writedata_in[4:0] : 5'h00))
				| irq_ev;
			if (wr_mask) begin
				irq_mask_reg <= avs_writedata_in[4:0];
			end
		end
	end

	assign irq_out = |(irq_stat_reg & irq_mask_reg);

	// ==================================================
	// Avalon-MM: one wait cycle, read data loaded in it
	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			acc_ack_reg <= 1'b0;
		end else begin
			acc_ack_reg <= acc_req & ~acc_ack_reg;
		end
	end

	assign avs_waitrequest_out = acc_req & ~acc_ack_reg;

	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			avs_readdata_out <= 32'h0000_0000;
		end else if (avs_read_in && !acc_ack_reg) begin
			case (acc_idx)
				`RSS_IDX_CAUSE:    avs_readdata_out <= {24'h00_0000, cause_reg};
				`RSS_IDX_PWRCTL2:  avs_readdata_out <= {24'h00_0000, pwrctl2_reg};
				`RSS_IDX_CONFIG:   avs_readdata_out <= {24'h00_0000, config_reg};
				`RSS_IDX_IRQ_STAT: avs_readdata_out <= {27'h000_0000, irq_stat_reg};
				`RSS_IDX_IRQ_MASK: avs_readdata_out <= {27'h000_0000, irq_mask_reg};
				default:           avs_readdata_out <= 32'h0000_0000;
			endcase
		end
	end

endmodule : rss_reset_startup_sequencer

`default_nettype wire

// File: rss_checker_assertions.sv
// rss_checker_assertions.sv: port checker for the reset and start-up sequencer
`default_nettype none

module rss_checker (
	// clock and reset
	input wire logic        clk_sys_in,
	input wire logic        arst_n_in,
	// supply, pin and core
	input wire logic        por_active_in,
	input wire logic        bor_active_in,
	input wire logic        external_reset_pin_n_in,
	input wire logic        exec_valid_in,
	input wire logic [14:0] exec_addr_in,
	input wire logic        core_reset_out,
	input wire logic        irq_block_out,
	// register bus
	input wire logic        avs_read_in,
	input wire logic        avs_write_in,
	input wire logic        avs_waitrequest_out
);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!arst_n_in);
	logic bad_w;
	// flash limit only: the storage-area enable is not visible at the ports
	assign bad_w = exec_valid_in && exec_addr_in >= 15'h2000 && !core_reset_out;
	// ==================================================
	// sequencing
	property p_sup; por_active_in || bor_active_in |-> ##[1:3] core_reset_out; endproperty
	a_sup: assert property (p_sup) else $error("core not held in supply reset");
	property p_rel;
		$fell(core_reset_out) |-> !$past(por_active_in, 11) && !$past(bor_active_in, 11);
	endproperty
	a_rel: assert property (p_rel) else $error("release too soon after supply");
	property p_pin; $fell(core_reset_out) |-> $past(external_reset_pin_n_in, 11); endproperty
	a_pin: assert property (p_pin) else $error("release too soon after pin");
	property p_plo; !external_reset_pin_n_in |-> ##[1:4] core_reset_out; endproperty
	a_plo: assert property (p_plo) else $error("pin low did not hold core");
	// ==================================================
	// execution violation, bus wait cycle and covers
	property p_vrs; bad_w |-> ##[1:2] core_reset_out; endproperty
	a_vrs: assert property (p_vrs) else $error("violation did not reset core");
	property p_blk; bad_w |-> irq_block_out; endproperty
	a_blk: assert property (p_blk) else $error("interrupts not blocked");
	property p_pre;
		irq_block_out |-> exec_valid_in && !core_reset_out && exec_addr_in >= 15'h1F80;
	endproperty
	a_pre: assert property (p_pre) else $error("block without execution");
	property p_bus;
		$rose(avs_read_in || avs_write_in) |-> avs_waitrequest_out ##1 !avs_waitrequest_out;
	endproperty
	a_bus: assert property (p_bus) else $error("bus wait cycle wrong");
	c_rel: cover property ($fell(core_reset_out));
	c_bad: cover property (bad_w);
	c_pin: cover property (!external_reset_pin_n_in && !core_reset_out);
endmodule : rss_checker

bind rss_reset_startup_sequencer rss_checker u_chk (.clk_sys_in, .arst_n_in, .por_active_in,
	.bor_active_in, .external_reset_pin_n_in, .exec_valid_in, .exec_addr_in, .core_reset_out,
	.irq_block_out, .avs_read_in, .avs_write_in, .avs_waitrequest_out);

`default_nettype wire

// File: rss_supply_model.sv
// rss_supply_model.sv: supply monitors and reset pin on the far side
`default_nettype none

module rss_supply_model (
	// requests from the bench
	input wire logic por_req_in,
	input wire logic bor_req_in,
	input wire logic pin_low_req_in,
	// detector and pin levels
	output logic     por_active_out,
	output logic     bor_active_out,
	output logic     external_reset_pin_n_out
);
	assign por_active_out = por_req_in;
	assign bor_active_out = bor_req_in;
	// pin has a pull-up: when nobody pulls it low it reads high
	assign external_reset_pin_n_out = !pin_low_req_in;
endmodule : rss_supply_model

`default_nettype wire

// File: tb.sv
// tb.sv: self-checking bench for the reset and start-up sequencer
`default_nettype none
`include "rss_defines.svh"

module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import rss_pkg::*;
	localparam logic [15:0] A_CAU = {`RSS_IDX_CAUSE, 2'b00};
	localparam logic [15:0] A_PC2 = {`RSS_IDX_PWRCTL2, 2'b00};
	localparam logic [15:0] A_CFG = {`RSS_IDX_CONFIG, 2'b00};
	localparam logic [15:0] A_STA = {`RSS_IDX_IRQ_STAT, 2'b00};
	localparam logic [15:0] A_MSK = {`RSS_IDX_IRQ_MASK, 2'b00};
	logic        clk_sys_in = 1'b0;
	logic        arst_n_in = 1'b0;
	logic        por_req = 1'b1;
	logic        bor_req = 1'b0;
	logic        pin_low = 1'b0;
	logic [4:0]  ev = 5'h0;
	logic        exec_valid_in = 1'b0;
	logic [14:0] exec_addr_in = 15'h0000;
	logic [15:0] avs_address_in = 16'h0000;
	logic        avs_read_in = 1'b0;
	logic        avs_write_in = 1'b0;
	logic [31:0] avs_writedata_in = 32'h0000_0000;
	wire logic   por_active_in, bor_active_in, external_reset_pin_n_in;
	wire logic   core_reset_out, irq_block_out, avs_waitrequest_out, irq_out;
	wire logic [31:0] avs_readdata_out;
	logic [7:0]  v;
	int          n, errors, compares, cyc;

	always #5 clk_sys_in = ~clk_sys_in;

	rss_supply_model u_sup (.por_req_in(por_req), .bor_req_in(bor_req), .pin_low_req_in(pin_low),
		.por_active_out(por_active_in), .bor_active_out(bor_active_in),
		.external_reset_pin_n_out(external_reset_pin_n_in));
	rss_reset_startup_sequencer #(.POWERUP_DELAY_TIMER_CYCLES(50), .OST_CYCLES(8)) dut (.clk_sys_in, .arst_n_in,
		.por_active_in, .bor_active_in, .external_reset_pin_n_in, .exec_valid_in, .exec_addr_in,
		.stack_over_in(ev[0]), .stack_under_in(ev[1]), .wdog_window_reset_in(ev[2]),
		.wdog_timeout_reset_in(ev[3]), .software_reset_in(ev[4]), .core_reset_out,
		.irq_block_out, .avs_address_in, .avs_read_in, .avs_write_in,
		.avs_byteenable_in(4'hf), .avs_writedata_in, .avs_readdata_out, .avs_waitrequest_out,
		.irq_out);

	// ==================================================
	// tasks
	task automatic stop_test();
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : stop_test
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// entered just after a rising edge; ends one idle cycle after release
	task automatic bus(input logic [15:0] a, input logic w, input logic [7:0] d);
		avs_address_in <= a;
		avs_writedata_in <= {24'h0, d};
		avs_read_in <= !w;
		avs_write_in <= w;
		// waits as long as the slave asks; only the bench timeout ends a hang
		do begin
			@(posedge clk_sys_in);
		end while (avs_waitrequest_out !== 1'b0);
		v = avs_readdata_out[7:0];
		avs_read_in <= 1'b0;
		avs_write_in <= 1'b0;
		@(posedge clk_sys_in);
	endtask : bus
	task automatic rc(input logic [15:0] a, input logic [7:0] e);
		bus(a, 1'b0, 8'h00);
		chk(v, e);
	endtask : rc
	task automatic tick(input int k);
		repeat (k) @(posedge clk_sys_in);
	endtask : tick
	// cycles until the core runs, sampled away from the edge
	task automatic rel();
		n = 0;
		do begin
			@(negedge clk_sys_in);
			n++;
		end while (core_reset_out !== 1'b0);
		@(posedge clk_sys_in);
	endtask : rel
	task automatic pulse(input int i);
		ev <= 5'h1 << i;
		tick(1);
		ev <= 5'h0;
		tick(2);
		rel();
	endtask : pulse
	// irq block is looked at mid-cycle, while the fetch stands
	task automatic ex(input logic [14:0] a, input logic vld, input logic eb);
		logic b;
		exec_addr_in <= a;
		exec_valid_in <= vld;
		@(negedge clk_sys_in);
		b = irq_block_out;
		tick(1);
		exec_valid_in <= 1'b0;
		chk({7'h0, b}, {7'h0, eb});
		tick(4);
	endtask : ex

	always @(posedge clk_sys_in) begin
		cyc++;
		if (cyc == 20000) begin
			errors++;
			stop_test();
		end
	end

	// ==================================================
	// tests
	initial begin
		tick(8);
		arst_n_in <= 1'b1;
		tick(1);
		rc(A_CAU, 8'h3d);
		rc(A_PC2, 8'h02);
		bus(16'h0000, 1'b1, 8'hff);
		rc(16'h0000, 8'h00);
		por_req <= 1'b0;
		rel();
		chk({7'h0, n >= 52 && n <= 66}, 8'h01);
		chk({7'h0, irq_out}, 8'h00);
		$display("end of power-on test");
		bus(A_CAU, 1'b1, 8'hff);
		pin_low <= 1'b1;
		bor_req <= 1'b1;
		tick(4);
		bor_req <= 1'b0;
		tick(100);
		chk({7'h0, core_reset_out}, 8'h01);
		pin_low <= 1'b0;
		rel();
		chk({7'h0, n >= 12 && n <= 15}, 8'h01);
		rc(A_CAU, 8'h3e);
		$display("end of pin hold test");
		pulse(0);
		pulse(1);
		rc(A_CAU, 8'hfe);
		pulse(2);
		rc(A_CAU, 8'hde);
		pulse(3);
		rc(A_CAU, 8'hce);
		pulse(4);
		pin_low <= 1'b1;
		tick(6);
		pin_low <= 1'b0;
		rel();
		rc(A_CAU, 8'hc2);
		$display("end of cause flag test");
		bus(A_CFG, 1'b1, 8'h08);
		bor_req <= 1'b1;
		tick(4);
		bor_req <= 1'b0;
		rel();
		chk({7'h0, n >= 12 && n <= 15}, 8'h01);
		bus(A_MSK, 1'b1, 8'h01);
		bus(A_STA, 1'b1, 8'h1f);
		ex(15'h1f80, 1'b1, 1'b0);
		ex(15'h7fff, 1'b0, 1'b0);
		rc(A_PC2, 8'h02);
		chk({7'h0, irq_out}, 8'h00);
		ex(15'h2000, 1'b1, 1'b1);
		rc(A_PC2, 8'h00);
		chk({7'h0, irq_out}, 8'h01);
		bus(A_STA, 1'b1, 8'h01);
		chk({7'h0, irq_out}, 8'h00);
		bus(A_PC2, 1'b1, 8'h02);
		bus(A_CFG, 1'b1, 8'h18);
		rel();
		ex(15'h1f80, 1'b1, 1'b1);
		rc(A_PC2, 8'h00);
		$display("end of violation test");
		stop_test();
	end
endmodule : tb

`default_nettype wire
